// *** hdl/ckus_device.sv ***
// device end: key detection, direct setup commands and pnp data port access
`timescale 1ns/1ps
// Behaviour
// - full first key enters direct setup
// - index port at 279h or two alternates
// - 06h then value sets card select
// - 15h then 0..5 selects logical device
// - 47h loads base 0 high, low
// - 48h loads base 1 high, low
// - 42h loads base 2 high, low
// - 22h/27h set interrupt selections
// - 2Ah/25h set dma selections
// - 33h 01h activates, 00h deactivates
// - 79h activates the whole chip
// - 55h/56h at control+5 set pnp_key_dis/key1_dis; of these two only key1_dis blocks a key
// - killed first key ignored, second key still works, devices act legacy
// - kills cleared only by bus reset
// - kills also settable from stored config
// - second key then byte captures port
// - data port is byte, then 11
// - port byte after second key enters pnp config state
// - data port read/write, index selects register
// - 02h index, 02h data leaves config
// - first key setup is write only
// - separate block bits for each key
module ckus_device (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host link
  ckus_bus_if.device bus,
  // strap and stored configuration
  input wire logic [1:0] idx_port_sel,
  input wire logic cfg_load,
  input wire logic pnp_key_block,
  input wire logic first_key_block,
  input wire logic second_key_block,
  // control block base decode
  input wire logic [11:0] control_block_base,
  // resulting configuration
  output logic [3:0] mode,
  output logic chip_active,
  output logic legacy,
  output logic pnp_key_dis,
  output logic key1_dis,
  output logic [7:0] card_select_number,
  output logic [9:0] config_data_port,
  output logic [2:0] ldev_sel,
  output logic [ckus_pkg::NUM_LDEV-1:0] ldev_active,
  output logic [ckus_pkg::NUM_LDEV*16-1:0] io_base0,
  output logic [ckus_pkg::NUM_LDEV*16-1:0] io_base1,
  output logic [ckus_pkg::NUM_LDEV*16-1:0] io_base2,
  output logic [ckus_pkg::NUM_LDEV*8-1:0] irq_sel0,
  output logic [ckus_pkg::NUM_LDEV*8-1:0] irq_sel1,
  output logic [ckus_pkg::NUM_LDEV*8-1:0] dma_sel0,
  output logic [ckus_pkg::NUM_LDEV*8-1:0] dma_sel1
);
  localparam int NL = ckus_pkg::NUM_LDEV;
  ckus_pkg::ckus_mode_t state;
  logic [5:0] k1_idx;
  logic [5:0] k2_idx;
  logic key2_dis;
  logic [7:0] cmd;
  logic [1:0] need;
  logic [7:0] hi_byte;
  logic [7:0] pnp_index;
  logic [9:0] idx_port;
  logic idx_wr;
  logic data_wr;
  logic data_rd;
  logic ctrl_wr;
  logic direct_config_method_wr;
  logic k1_hit;
  logic k2_hit;
  logic [7:0] next_rdata;

  assign mode = state;
  assign key2_dis = second_key_block;

  // index port choice
  always_comb begin
    unique case (idx_port_sel)
      ckus_pkg::SEL_ALT1: idx_port = ckus_pkg::IDX_PORT_ALT1;
      ckus_pkg::SEL_ALT2: idx_port = ckus_pkg::IDX_PORT_ALT2;
      default: idx_port = ckus_pkg::IDX_PORT_STD;
    endcase
  end

  assign idx_wr = bus.wr && (bus.addr[9:0] == idx_port) && (bus.addr[11:10] == 2'h0);
  assign data_wr = bus.wr && (state == ckus_pkg::CKUS_PNP) && (bus.addr[11:10] == 2'h0)
                   && (bus.addr[9:0] == config_data_port);
  assign data_rd = bus.rd && (state == ckus_pkg::CKUS_PNP) && (bus.addr[11:10] == 2'h0)
                   && (bus.addr[9:0] == config_data_port);
  assign ctrl_wr = bus.wr && chip_active
                   && (bus.addr == control_block_base + {9'h000, ckus_pkg::CTRL_KEY_OFS});
  assign direct_config_method_wr = idx_wr && (state == ckus_pkg::CKUS_DIRECT_CONFIG_METHOD);
  assign k1_hit = idx_wr && !key1_dis && !first_key_block
                  && (bus.wdata == ckus_pkg::KEY1[k1_idx[4:0]]);
  assign k2_hit = idx_wr && !key2_dis && (bus.wdata == ckus_pkg::KEY2[k2_idx[4:0]]);

  always_ff @(posedge clk) begin
    if (!rst_n || state != ckus_pkg::CKUS_WAIT) begin
      k1_idx <= ckus_pkg::KEY_IDX_RST;
      k2_idx <= ckus_pkg::KEY_IDX_RST;
    end else if (idx_wr) begin
      k1_idx <= k1_hit ? k1_idx + 6'h01 : ckus_pkg::KEY_IDX_RST;
      k2_idx <= k2_hit ? k2_idx + 6'h01 : ckus_pkg::KEY_IDX_RST;
    end
  end

  // mode sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ckus_pkg::CKUS_WAIT;
    end else begin
      unique case (state)
        ckus_pkg::CKUS_WAIT: begin
          if (k1_hit && k1_idx == 6'(ckus_pkg::KEY_LEN - 1)) begin
            state <= ckus_pkg::CKUS_DIRECT_CONFIG_METHOD;
          end else if (k2_hit && k2_idx == 6'(ckus_pkg::KEY_LEN - 1)) begin
            state <= ckus_pkg::CKUS_GRAB;
          end
        end
        ckus_pkg::CKUS_DIRECT_CONFIG_METHOD: begin
          if (direct_config_method_wr && need == 2'h0 && bus.wdata == ckus_pkg::CMD_CHIP_ON) begin
            state <= ckus_pkg::CKUS_WAIT;
          end
        end
        ckus_pkg::CKUS_GRAB: begin
          if (idx_wr) begin
            state <= ckus_pkg::CKUS_PNP;
          end
        end
        ckus_pkg::CKUS_PNP: begin
          if (data_wr && pnp_index == ckus_pkg::PNP_CFG_CTRL
              && bus.wdata == ckus_pkg::PNP_WAIT_KEY) begin
            state <= ckus_pkg::CKUS_WAIT;
          end
        end
        default: state <= ckus_pkg::CKUS_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      config_data_port <= ckus_pkg::DATA_PORT_RST;
    end else if (state == ckus_pkg::CKUS_GRAB && idx_wr) begin
      config_data_port <= {bus.wdata, ckus_pkg::DATA_PORT_LOW};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pnp_index <= 8'h00;
    end else if (state == ckus_pkg::CKUS_PNP && idx_wr) begin
      pnp_index <= bus.wdata;
    end
  end

  // direct setup command parser; need counts data bytes still due
  always_ff @(posedge clk) begin
    if (!rst_n || state != ckus_pkg::CKUS_DIRECT_CONFIG_METHOD) begin
      cmd <= 8'h00;
      need <= 2'h0;
      hi_byte <= 8'h00;
    end else if (direct_config_method_wr) begin
      if (need == 2'h0) begin
        cmd <= bus.wdata;
        unique case (bus.wdata)
          ckus_pkg::CMD_IO0, ckus_pkg::CMD_IO1, ckus_pkg::CMD_IO2: need <= 2'h2;
          ckus_pkg::CMD_CSN, ckus_pkg::CMD_LDN, ckus_pkg::CMD_IRQ0, ckus_pkg::CMD_IRQ1,
          ckus_pkg::CMD_DMA0, ckus_pkg::CMD_DMA1, ckus_pkg::CMD_ACT: need <= 2'h1;
          default: need <= 2'h0;
        endcase
      end else begin
        hi_byte <= bus.wdata;
        need <= need - 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      card_select_number <= ckus_pkg::CSN_RST;
      ldev_sel <= 3'h0;
      ldev_active <= '0;
      io_base0 <= '0;
      io_base1 <= '0;
      io_base2 <= '0;
      irq_sel0 <= '0;
      irq_sel1 <= '0;
      dma_sel0 <= '0;
      dma_sel1 <= '0;
    end else if (direct_config_method_wr && need == 2'h1) begin
      unique case (cmd)
        ckus_pkg::CMD_CSN: card_select_number <= bus.wdata;
        ckus_pkg::CMD_LDN: if (bus.wdata <= ckus_pkg::MAX_LDEV) ldev_sel <= bus.wdata[2:0];
        ckus_pkg::CMD_IO0: io_base0[ldev_sel*16 +: 16] <= {hi_byte, bus.wdata};
        ckus_pkg::CMD_IO1: io_base1[ldev_sel*16 +: 16] <= {hi_byte, bus.wdata};
        ckus_pkg::CMD_IO2: io_base2[ldev_sel*16 +: 16] <= {hi_byte, bus.wdata};
        ckus_pkg::CMD_IRQ0: irq_sel0[ldev_sel*8 +: 8] <= bus.wdata;
        ckus_pkg::CMD_IRQ1: irq_sel1[ldev_sel*8 +: 8] <= bus.wdata;
        ckus_pkg::CMD_DMA0: dma_sel0[ldev_sel*8 +: 8] <= bus.wdata;
        ckus_pkg::CMD_DMA1: dma_sel1[ldev_sel*8 +: 8] <= bus.wdata;
        ckus_pkg::CMD_ACT: begin
          if (bus.wdata == ckus_pkg::VAL_ON) ldev_active[ldev_sel] <= 1'b1;
          else if (bus.wdata == ckus_pkg::VAL_OFF) ldev_active[ldev_sel] <= 1'b0;
        end
        default: ;
      endcase
    // data port writes reach the indexed register
    end else if (data_wr) begin
      unique case (pnp_index)
        8'h06: card_select_number <= bus.wdata;
        8'h07: if (bus.wdata <= ckus_pkg::MAX_LDEV) ldev_sel <= bus.wdata[2:0];
        8'h30: ldev_active[ldev_sel] <= bus.wdata[0];
        8'h60: io_base0[ldev_sel*16+8 +: 8] <= bus.wdata;
        8'h61: io_base0[ldev_sel*16 +: 8] <= bus.wdata;
        8'h70: irq_sel0[ldev_sel*8 +: 8] <= bus.wdata;
        8'h74: dma_sel0[ldev_sel*8 +: 8] <= bus.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chip_active <= 1'b0;
    end else if (direct_config_method_wr && need == 2'h0 && bus.wdata == ckus_pkg::CMD_CHIP_ON) begin
      chip_active <= 1'b1;
    end
  end

  // only bus reset clears the kills
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pnp_key_dis <= 1'b0;
      key1_dis <= 1'b0;
    end else begin
      // stored config load; host kill writes
      if ((cfg_load && pnp_key_block) || (ctrl_wr && bus.wdata == ckus_pkg::KILL_PNP))
        pnp_key_dis <= 1'b1;
      if ((cfg_load && first_key_block) || (ctrl_wr && bus.wdata == ckus_pkg::KILL_KEY1))
        key1_dis <= 1'b1;
    end
  end

  assign legacy = pnp_key_dis || key1_dis;

  // read data sits one cycle after the read strobe; zero when unmapped
  always_comb begin
    next_rdata = 8'h00;
    if (data_rd) begin
      unique case (pnp_index)
        8'h06: next_rdata = card_select_number;
        8'h07: next_rdata = {5'h00, ldev_sel};
        8'h30: next_rdata = {7'h00, ldev_active[ldev_sel]};
        8'h60: next_rdata = io_base0[ldev_sel*16+8 +: 8];
        8'h61: next_rdata = io_base0[ldev_sel*16 +: 8];
        8'h70: next_rdata = irq_sel0[ldev_sel*8 +: 8];
        8'h74: next_rdata = dma_sel0[ldev_sel*8 +: 8];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) bus.rdata <= 8'h00;
    else bus.rdata <= next_rdata;
  end
endmodule

// *** hdl/ckus_pkg.sv ***
// constants shared by both ends of the configuration key and direct setup link
package ckus_pkg;
  localparam logic [9:0] IDX_PORT_STD = 10'h279;
  localparam logic [9:0] IDX_PORT_ALT1 = 10'h20F;
  localparam logic [9:0] IDX_PORT_ALT2 = 10'h3E0;
  localparam logic [9:0] WR_DATA_PORT = 10'h279;
  localparam logic [2:0] CTRL_KEY_OFS = 3'h5;
  localparam logic [7:0] CMD_CSN = 8'h06;
  localparam logic [7:0] CMD_LDN = 8'h15;
  localparam logic [7:0] CMD_IO0 = 8'h47;
  localparam logic [7:0] CMD_IO1 = 8'h48;
  localparam logic [7:0] CMD_IO2 = 8'h42;
  localparam logic [7:0] CMD_IRQ0 = 8'h22;
  localparam logic [7:0] CMD_IRQ1 = 8'h27;
  localparam logic [7:0] CMD_DMA0 = 8'h2A;
  localparam logic [7:0] CMD_DMA1 = 8'h25;
  localparam logic [7:0] CMD_ACT = 8'h33;
  localparam logic [7:0] CMD_CHIP_ON = 8'h79;
  localparam logic [7:0] VAL_ON = 8'h01;
  localparam logic [7:0] VAL_OFF = 8'h00;
  localparam logic [7:0] KILL_PNP = 8'h55;
  localparam logic [7:0] KILL_KEY1 = 8'h56;
  localparam logic [7:0] PNP_CFG_CTRL = 8'h02;
  localparam logic [7:0] PNP_WAIT_KEY = 8'h02;
  localparam logic [1:0] DATA_PORT_LOW = 2'h3;
  localparam int NUM_LDEV = 6;
  localparam logic [7:0] MAX_LDEV = 8'h05;
  localparam int KEY_LEN = 32;
  localparam logic [7:0] KEY1 [0:31] = '{
    8'h96, 8'h35, 8'h9A, 8'hCD, 8'hE6, 8'hF3, 8'h79, 8'hBC,
    8'h5E, 8'hAF, 8'h57, 8'h2B, 8'h15, 8'h8A, 8'hC5, 8'hE2,
    8'hF1, 8'hF8, 8'h7C, 8'h3E, 8'h9F, 8'h4F, 8'h27, 8'h13,
    8'h09, 8'h84, 8'h42, 8'hA1, 8'hD0, 8'h68, 8'h34, 8'h1A};
  localparam logic [7:0] KEY2 [0:31] = '{
    8'h95, 8'hB1, 8'hD8, 8'h6C, 8'h36, 8'h9B, 8'h4D, 8'hA6,
    8'hD3, 8'h69, 8'hB4, 8'h5A, 8'hAD, 8'hD6, 8'hEB, 8'h75,
    8'hBA, 8'hDD, 8'hEE, 8'hF7, 8'h7B, 8'h3D, 8'h9E, 8'hCF,
    8'h67, 8'h33, 8'h19, 8'h8C, 8'h46, 8'hA3, 8'h51, 8'hA8};
  localparam logic [5:0] KEY_IDX_RST = 6'h00;
  localparam logic [7:0] CSN_RST = 8'h00;
  localparam logic [9:0] DATA_PORT_RST = 10'h000;
  localparam logic [1:0] SEL_STD = 2'h0;
  localparam logic [1:0] SEL_ALT1 = 2'h1;
  localparam logic [1:0] SEL_ALT2 = 2'h2;
  // device configuration modes
  typedef enum logic [3:0] {
    CKUS_WAIT = 4'b0001,
    CKUS_DIRECT_CONFIG_METHOD = 4'b0010,
    CKUS_GRAB = 4'b0100,
    CKUS_PNP = 4'b1000
  } ckus_mode_t;
  // host bus cycle kinds
  localparam logic [1:0] HOP_IDX = 2'h0;
  localparam logic [1:0] HOP_DWR = 2'h1;
  localparam logic [1:0] HOP_DRD = 2'h2;
  localparam logic [1:0] HOP_CTRL = 2'h3;
endpackage

// *** hdl/ckus_bus_if.sv ***
// isa-style cycle link between the host end and the device end
`timescale 1ns/1ps
interface ckus_bus_if;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport host (output addr, output wdata, output wr, output rd, input rdata);
  modport device (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// *** hdl/ckus_host.sv ***
// host end: turns software register orders into configuration bus cycles
`timescale 1ns/1ps
module ckus_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // software register port
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // device link
  ckus_bus_if.host bus
);
  // software registers: 0 target port, 1 issue cycle, 2 last read byte, 3 data port byte
  logic [11:0] target;
  logic [7:0] last_rd;
  logic rd_pend;
  logic [1:0] op;
  logic [9:0] data_port;

  // target port for control cycles; data port address is set by software through register 3 as byte then 11
  always_ff @(posedge clk) begin
    if (!rst_n) target <= 12'h000;
    else if (sw_wr && sw_addr == 4'h0) target <= sw_wdata[11:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) data_port <= 10'h000;
    else if (sw_wr && sw_addr == 4'h3) data_port <= {sw_wdata[7:0], ckus_pkg::DATA_PORT_LOW};
  end

  assign op = sw_wdata[9:8];

  // key and command bytes go out one per cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.addr <= 12'h000;
      bus.wdata <= 8'h00;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
    end else begin
      bus.wr <= sw_wr && sw_addr == 4'h1 && op != ckus_pkg::HOP_DRD;
      bus.rd <= sw_wr && sw_addr == 4'h1 && op == ckus_pkg::HOP_DRD;
      if (sw_wr && sw_addr == 4'h1) begin
        bus.wdata <= sw_wdata[7:0];
        unique case (op)
          ckus_pkg::HOP_IDX: bus.addr <= {2'h0, ckus_pkg::IDX_PORT_STD};
          ckus_pkg::HOP_DWR, ckus_pkg::HOP_DRD: bus.addr <= {2'h0, data_port};
          ckus_pkg::HOP_CTRL: bus.addr <= target;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) rd_pend <= 1'b0;
    else rd_pend <= bus.rd;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) last_rd <= 8'h00;
    else if (rd_pend) last_rd <= bus.rdata;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) sw_rdata <= 16'h0000;
    else if (sw_rd) begin
      unique case (sw_addr)
        4'h0: sw_rdata <= {4'h0, target};
        4'h2: sw_rdata <= {8'h00, last_rd};
        4'h3: sw_rdata <= {6'h00, data_port};
        default: sw_rdata <= 16'h0000;
      endcase
    end else sw_rdata <= 16'h0000;
  end
endmodule

// *** tb/ckus_bus_assertions.sv ***
// bus and mode checks on the link between host end and device end
`timescale 1ns/1ps
module ckus_bus_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link signals
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // device state
  input wire logic [3:0] mode,
  input wire logic chip_active,
  input wire logic key1_dis,
  input wire logic [7:0] card_select_number,
  input wire logic [9:0] config_data_port
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  key1_enter_a:
    assert property ($rose(mode[1]) |-> $past(wr) && $past(wdata) == 8'h1A && $past(mode) == 4'h1)
    else $error("direct setup entered without final key byte");
  key2_enter_a:
    assert property ($rose(mode[2]) |-> $past(wr) && $past(wdata) == 8'hA8)
    else $error("port byte wait entered without final key byte");
  port_form_a:
    assert property ($rose(mode[3]) |-> config_data_port == {$past(wdata), 2'b11}
      && $past(mode) == 4'h4) else $error("data port address formed wrongly");
  chip_on_a:
    assert property ($rose(chip_active) |-> $past(wdata) == 8'h79 && $past(mode) == 4'h2
      && mode == 4'h1) else $error("chip activated without its command");
  leave_cfg_a:
    assert property ($past(mode) == 4'h8 && mode == 4'h1 |-> $past(wr) && $past(wdata) == 8'h02)
    else $error("config state left without wait command");
  cmd_gate_a:
    assert property ($changed(card_select_number) |-> $past(mode) == 4'h2 || $past(mode) == 4'h8)
    else $error("card select changed outside setup");
  no_read_key1_a:
    assert property ($past(rd) && $past(mode) != 4'h8 |-> rdata == 8'h00)
    else $error("read data returned outside config state");
  rdata_idle_a:
    assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data present without a read");
  key1_dead_a:
    assert property ($rose(mode[1]) |-> !$past(key1_dis))
    else $error("disabled key still accepted");
endmodule

// *** tb/tb_top.sv ***
// bench joining host end and device end, driven through the software port
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic rst_n;
  logic [3:0] sw_addr;
  logic [15:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [15:0] sw_rdata;
  logic [1:0] idx_port_sel;
  logic cfg_load;
  logic pnp_key_block;
  logic first_key_block;
  logic second_key_block;
  logic [11:0] control_block_base;
  logic [3:0] mode;
  logic chip_active;
  logic legacy;
  logic pnp_key_dis;
  logic key1_dis;
  logic [7:0] card_select_number;
  logic [9:0] config_data_port;
  logic [2:0] ldev_sel;
  logic [5:0] ldev_active;
  logic [95:0] io_base0;
  logic [95:0] io_base1;
  logic [95:0] io_base2;
  logic [47:0] irq_sel0;
  logic [47:0] irq_sel1;
  logic [47:0] dma_sel0;
  logic [47:0] dma_sel1;
  int error_cnt;
  int checks_done;
  // direct setup order stream: card select, device 3, refused device 6, bases, irq, dma, on
  localparam logic [7:0] DIRECT_CONFIG_METHOD_SEQ [0:24] = '{8'h06, 8'h01, 8'h15, 8'h03, 8'h15, 8'h06, 8'h47,
    8'h05, 8'h34, 8'h48, 8'h03, 8'h88, 8'h42, 8'h02, 8'h20, 8'h22, 8'h05, 8'h27, 8'h09, 8'h2A,
    8'h01, 8'h25, 8'h03, 8'h33, 8'h01};
  ckus_bus_if bus ();
  ckus_host i_ckus_host (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(bus.host));
  ckus_device i_ckus_device (.clk(clk), .rst_n(rst_n), .bus(bus.device),
    .idx_port_sel(idx_port_sel), .cfg_load(cfg_load), .pnp_key_block(pnp_key_block),
    .first_key_block(first_key_block), .second_key_block(second_key_block),
    .control_block_base(control_block_base), .mode(mode), .chip_active(chip_active),
    .legacy(legacy), .pnp_key_dis(pnp_key_dis), .key1_dis(key1_dis),
    .card_select_number(card_select_number), .config_data_port(config_data_port),
    .ldev_sel(ldev_sel), .ldev_active(ldev_active), .io_base0(io_base0), .io_base1(io_base1),
    .io_base2(io_base2), .irq_sel0(irq_sel0), .irq_sel1(irq_sel1), .dma_sel0(dma_sel0),
    .dma_sel1(dma_sel1));
  ckus_bus_assertions i_ckus_bus_assertions (.clk(clk), .rst_n(rst_n), .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .mode(mode),
    .chip_active(chip_active), .key1_dis(key1_dis), .card_select_number(card_select_number),
    .config_data_port(config_data_port));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask
  // one bus cycle per order; a gap cycle keeps the strobe clean
  task automatic issue(input logic [1:0] op, input logic [7:0] b);
    sw_write(4'h1, {6'h00, op, b});
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic send_key(input bit second);
    for (int i = 0; i < ckus_pkg::KEY_LEN; i++) begin
      issue(ckus_pkg::HOP_IDX, second ? ckus_pkg::KEY2[i] : ckus_pkg::KEY1[i]);
    end
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // a hang is cut at 20000 cycles, well beyond the several hundred cycles the run needs
  initial begin
    #(20000 * 100);
    error_cnt++;
    print_verdict();
  end
  initial begin
    logic [15:0] rv;
    error_cnt = 0;
    checks_done = 0;
    rst_n = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    idx_port_sel = ckus_pkg::SEL_STD;
    cfg_load = 1'b0;
    pnp_key_block = 1'b0;
    first_key_block = 1'b0;
    second_key_block = 1'b0;
    control_block_base = 12'h120;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    issue(ckus_pkg::HOP_IDX, ckus_pkg::CMD_CSN);
    issue(ckus_pkg::HOP_IDX, 8'h44);
    settle();
    chk("csn idle", 16'h0000, {8'h00, card_select_number});
    for (int i = 0; i < 10; i++) issue(ckus_pkg::HOP_IDX, ckus_pkg::KEY1[i]);
    issue(ckus_pkg::HOP_IDX, 8'h00);
    for (int i = 10; i < 32; i++) issue(ckus_pkg::HOP_IDX, ckus_pkg::KEY1[i]);
    settle();
    chk("broken key", 16'h0001, {12'h000, mode});
    send_key(1'b0);
    settle();
    chk("key1 mode", 16'h0002, {12'h000, mode});
    for (int i = 0; i < 25; i++) issue(ckus_pkg::HOP_IDX, DIRECT_CONFIG_METHOD_SEQ[i]);
    settle();
    chk("csn", 16'h0001, {8'h00, card_select_number});
    chk("ldev", 16'h0003, {13'h0000, ldev_sel});
    chk("io0", 16'h0534, io_base0[48+:16]);
    chk("io1", 16'h0388, io_base1[48+:16]);
    chk("io2", 16'h0220, io_base2[48+:16]);
    chk("irq", 16'h0509, {irq_sel0[24+:8], irq_sel1[24+:8]});
    chk("dma", 16'h0103, {dma_sel0[24+:8], dma_sel1[24+:8]});
    chk("act on", 16'h0008, {10'h000, ldev_active});
    issue(ckus_pkg::HOP_IDX, ckus_pkg::CMD_ACT);
    issue(ckus_pkg::HOP_IDX, ckus_pkg::VAL_OFF);
    issue(ckus_pkg::HOP_DRD, 8'h00);
    settle();
    chk("act off", 16'h0000, {10'h000, ldev_active});
    issue(ckus_pkg::HOP_IDX, ckus_pkg::CMD_CHIP_ON);
    settle();
    chk("chip on", 16'h0011, {11'h000, chip_active, mode});
    sw_write(4'h0, 16'h0125);
    issue(ckus_pkg::HOP_CTRL, ckus_pkg::KILL_KEY1);
    settle();
    chk("kill key1", 16'h0011, {11'h000, key1_dis, 3'h0, legacy});
    send_key(1'b0);
    issue(ckus_pkg::HOP_CTRL, ckus_pkg::KILL_PNP);
    settle();
    chk("key1 dead", 16'h0011, {11'h000, pnp_key_dis, mode});
    @(posedge clk);
    idx_port_sel <= ckus_pkg::SEL_ALT1;
    send_key(1'b1);
    settle();
    chk("alt port", 16'h0001, {12'h000, mode});
    idx_port_sel <= ckus_pkg::SEL_STD;
    second_key_block <= 1'b1;
    send_key(1'b1);
    settle();
    chk("key2 block", 16'h0001, {12'h000, mode});
    second_key_block <= 1'b0;
    sw_write(4'h3, 16'h0082);
    send_key(1'b1);
    settle();
    chk("key2 mode", 16'h0004, {12'h000, mode});
    issue(ckus_pkg::HOP_IDX, 8'h82);
    settle();
    chk("data port", 16'h020B, {6'h00, config_data_port});
    chk("pnp mode", 16'h0008, {12'h000, mode});
    issue(ckus_pkg::HOP_IDX, ckus_pkg::CMD_CSN);
    issue(ckus_pkg::HOP_DWR, 8'h05);
    issue(ckus_pkg::HOP_DRD, 8'h00);
    settle();
    sw_read(4'h2, rv);
    chk("csn rw", 16'h0505, {card_select_number, rv[7:0]});
    issue(ckus_pkg::HOP_IDX, ckus_pkg::PNP_CFG_CTRL);
    issue(ckus_pkg::HOP_DWR, ckus_pkg::PNP_WAIT_KEY);
    settle();
    chk("wait key", 16'h0001, {12'h000, mode});
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk("kills clear", 16'h0000, {14'h0000, pnp_key_dis, key1_dis});
    first_key_block <= 1'b1;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    send_key(1'b0);
    settle();
    chk("stored kill", 16'h0011, {11'h000, key1_dis, mode});
    print_verdict();
  end
endmodule
